// File: rtl/chan_pkg.sv
// Purpose: Shared constants and types for the serial channel parameter block
// Assumes: 250 MHz system clock; register index times four gives the byte address
// Notes: All parameter registers clear to zero at reset
package chan_pkg;

  // Register indices (byte address = index * 4)
  localparam logic [7:0] IDX_FIRST_SYNC = 8'h08;
  localparam logic [7:0] IDX_SECOND_SYNC = 8'h09;
  localparam logic [7:0] IDX_SPECIAL = 8'h0a;
  localparam logic [7:0] IDX_SYNC_COUNT = 8'h0b;
  localparam logic [7:0] IDX_RECORD_LEN = 8'h0c;
  localparam logic [7:0] IDX_FLAGS = 8'h0e;
  localparam logic [7:0] IDX_IDLE_FILL = 8'h10;
  localparam logic [7:0] IDX_THRESHOLD = 8'h12;
  localparam logic [7:0] IDX_PAD_CHAR = 8'h14;
  localparam logic [7:0] IDX_PAD_COUNT = 8'h15;
  localparam logic [7:0] IDX_OPEN_HOLD = 8'h16;
  localparam logic [7:0] IDX_CONTROL = 8'h40;
  localparam logic [7:0] IDX_TX_LENGTH = 8'h41;
  localparam logic [7:0] IDX_TX_DATA = 8'h42;
  localparam logic [7:0] IDX_STATUS = 8'h43;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h44;
  localparam logic [7:0] IDX_CHAN_STATE = 8'h45;

  // Service flag word fields
  localparam int FLAG_RX_CLEAR = 4;
  localparam int FLAG_SPLIT_QUEUES = 5;
  localparam int FLAG_RTS_ON_OPEN = 6;
  localparam int FLAG_WAIT_DCD = 7;
  localparam int FLAG_DROP_RTS = 8;
  localparam int FLAG_IGNORE_DSR = 11;
  localparam int FLAG_MODE_LSB = 13;
  localparam int SPECIAL_TRANSPARENT = 0;

  // Control register fields
  localparam int CTL_CONT_RTS = 0;
  localparam int CTL_OPEN = 1;
  localparam int CTL_TX_GO = 2;
  localparam int CTL_CLOSE = 3;

  // Status and mask fields
  localparam int ST_TX_DONE = 0;
  localparam int ST_OPEN_DONE = 1;
  localparam int ST_DSR_LOST = 2;
  localparam int ST_WIDTH = 3;

  // Output FIFO
  localparam int FIFO_DEPTH = 16;
  localparam logic [15:0] FIFO_DEPTH_W = 16'h0010;

  // Timing
  localparam int QTR_SEC_NS = 250_000_000;
  localparam int CLK_PERIOD_NS = 4;
  localparam int QTR_CYCLES_DEF = QTR_SEC_NS / CLK_PERIOD_NS;
  localparam int QTR_SEC_MS = 250;
  localparam int MINUTE_MS = 60_000;
  localparam int QTRS_PER_MIN = MINUTE_MS / QTR_SEC_MS;
  localparam int TIMER_COUNT = 4;

  // Kind of byte held on the line output
  localparam logic [1:0] K_IDLE = 2'h0;
  localparam logic [1:0] K_SYNC = 2'h1;
  localparam logic [1:0] K_DATA = 2'h2;
  localparam logic [1:0] K_PAD = 2'h3;

  typedef enum logic [2:0] {
    bit_oriented_mode = 3'h0,
    char_oriented_mode = 3'h2,
    async_mode = 3'h4
  } line_mode_e;

  typedef enum logic [2:0] {
    TX_IDLE = 3'h0,
    TX_FILL = 3'h1,
    TX_SYNC = 3'h3,
    TX_DATA = 3'h2,
    TX_PAD = 3'h6
  } tx_state_e;

  typedef enum logic [1:0] {
    O_IDLE = 2'h0,
    O_WAIT = 2'h1,
    O_UP = 2'h3
  } open_state_e;

endpackage

// File: rtl/tick_prescaler.sv
// Purpose: Free-running quarter-second and one-minute tick source
// Assumes: Single system clock
// Notes: Ticks are one-cycle pulses
`timescale 1ns/1ps
module tick_prescaler
  import chan_pkg::*;
#(
  parameter int QTR_CYCLES = QTR_CYCLES_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Ticks
  output logic qtr_tick,
  output logic min_tick
);

  typedef struct packed {
    logic [25:0] cnt;
    logic [7:0] qcnt;
    logic q;
    logic m;
  } pre_s;

  localparam logic [25:0] CNT_LAST = 26'(QTR_CYCLES - 1);
  localparam logic [7:0] QCNT_LAST = 8'(QTRS_PER_MIN - 1);

  pre_s p_reg;
  pre_s p_next;

  always_comb begin
    p_next = p_reg;
    p_next.q = 1'b0;
    p_next.m = 1'b0;
    if (p_reg.cnt >= CNT_LAST) begin
      p_next.cnt = '0;
      p_next.q = 1'b1;
      if (p_reg.qcnt >= QCNT_LAST) begin
        p_next.qcnt = '0;
        p_next.m = 1'b1;
      end else begin
        p_next.qcnt = p_reg.qcnt + 8'h01;
      end
    end else begin
      p_next.cnt = p_reg.cnt + 26'h0000001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      p_reg <= '0;
    end else begin
      p_reg <= p_next;
    end
  end

  assign qtr_tick = p_reg.q;
  assign min_tick = p_reg.m;

endmodule

// File: rtl/sync_serial_channel_params.sv
// Purpose: Channel parameter table, transmit framer and open sequencer
// Assumes: Avalon-MM slave, byte address; byte serializer on tx_valid/tx_ready
// Notes: Modem inputs are synchronised; line side handshakes share clk
// How it works
// - Second sync register byte drives the serializer's second sync output.
// - Special modifiers bit 0 turns transparency on; other bits reserved.
// - Each frame starts with first sync char sent initial-sync-count times.
// - Transmit record length word is held and driven to character detection.
// - Flag bits 0-3 pick quarter-second or minute ticks per channel timer.
// - With flag bit 4 set, receiver is cleared after every received frame.
// - Flag bit 5 selects single or split transmit/receive request queues.
// - Flag bit 6 raises request-to-send when an open starts.
// - Flag bit 7 holds open completion until carrier detect is present.
// - Flag bit 8 drops request-to-send once the open completes.
// - Flag bit 11 clear means wait for and monitor data-set-ready.
// - Flag bits 13-15 decode line mode: bit, char sync, or async.
// - Continuous request-to-send with nothing pending sends the idle fill byte.
// - Line data waits until threshold bytes, at most the FIFO depth of 16, sit in the output FIFO.
// - Requests shorter than the threshold wait for their whole data.
// - Each block ends with the pad byte sent pad-count times.
// - Open succeeds only after modem lines hold required state for hold timer.
// - First sync register byte drives the serializer's first sync output.
`timescale 1ns/1ps
module sync_serial_channel_params
  import chan_pkg::*;
#(
  parameter int QTR_CYCLES = QTR_CYCLES_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [9:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic irq,
  // Serial controller configuration
  output logic [7:0] first_sync_char,
  output logic [7:0] second_sync_char,
  output logic transparent_en,
  output logic [15:0] transmit_record_length,
  output logic split_queues,
  output logic [2:0] line_mode,
  output logic line_mode_known,
  output logic [3:0] timer_tick,
  // Line byte stream
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic rx_frame_end,
  output logic rx_clear,
  // Modem control
  input wire logic dcd,
  input wire logic dsr,
  output logic rts
);

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [7:0] first_sync;
    logic [7:0] second_sync;
    logic [7:0] special;
    logic [7:0] sync_count;
    logic [15:0] record_len;
    logic [15:0] flags;
    logic [15:0] idle_fill;
    logic [15:0] threshold;
    logic [7:0] pad_char;
    logic [7:0] pad_count;
    logic [7:0] open_hold;
    logic cont_rts;
    logic [15:0] tx_len;
    logic [ST_WIDTH-1:0] status;
    logic [ST_WIDTH-1:0] mask;
    logic [FIFO_DEPTH-1:0][7:0] mem;
    logic [3:0] wr_ptr;
    logic [3:0] rd_ptr;
    logic [4:0] fifo_cnt;
    tx_state_e tx_st;
    logic [15:0] tx_left;
    logic [7:0] rep_left;
    logic [7:0] tx_byte;
    logic tx_vld;
    logic [1:0] tx_kind;
    open_state_e op_st;
    logic [7:0] hold_cnt;
    logic rts;
    logic rx_clr;
    logic [3:0] ticks;
    logic dcd_s1;
    logic dcd_s2;
    logic dsr_s1;
    logic dsr_s2;
  } chan_s;

  chan_s s_reg;
  chan_s s_next;
  logic qtr_tick;
  logic min_tick;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    return be[0] ? wd[7:0] : old;
  endfunction

  tick_prescaler #(
    .QTR_CYCLES(QTR_CYCLES)
  ) u_prescaler (
    .clk(clk),
    .rst(rst),
    .qtr_tick(qtr_tick),
    .min_tick(min_tick)
  );

  logic [7:0] idx;
  logic wr_acc;
  logic rd_acc;
  logic fifo_full;
  logic line_ok;
  logic open_pulse;
  logic close_pulse;
  logic go_pulse;
  logic can_load;
  logic [15:0] fill_target;
  logic [15:0] fifo_cnt_w;
  logic [ST_WIDTH-1:0] ev;

  assign idx = address[9:2];
  assign fifo_full = s_reg.fifo_cnt == 5'(FIFO_DEPTH);
  assign wr_acc = s_reg.ack & write;
  assign rd_acc = s_reg.ack & read;
  assign fifo_cnt_w = {11'h000, s_reg.fifo_cnt};
  assign line_ok = (!s_reg.flags[FLAG_WAIT_DCD] | s_reg.dcd_s2) &
                   (s_reg.flags[FLAG_IGNORE_DSR] | s_reg.dsr_s2);
  assign can_load = !s_reg.tx_vld | tx_ready;
  assign open_pulse = wr_acc & (idx == IDX_CONTROL) & byteenable[0] & writedata[CTL_OPEN];
  assign close_pulse = wr_acc & (idx == IDX_CONTROL) & byteenable[0] & writedata[CTL_CLOSE];
  assign go_pulse = wr_acc & (idx == IDX_CONTROL) & byteenable[0] & writedata[CTL_TX_GO];

  // Fill target: threshold, or the whole request when shorter, capped at depth
  always_comb begin
    fill_target = (s_reg.tx_len < s_reg.threshold) ? s_reg.tx_len : s_reg.threshold;
    if (fill_target > FIFO_DEPTH_W) begin
      fill_target = FIFO_DEPTH_W;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_next = s_reg;
    ev = '0;
    s_next.rx_clr = rx_frame_end & s_reg.flags[FLAG_RX_CLEAR];
    for (int i = 0; i < TIMER_COUNT; i++) begin
      s_next.ticks[i] = s_reg.flags[i] ? min_tick : qtr_tick;
    end
    s_next.dcd_s1 = dcd;
    s_next.dcd_s2 = s_reg.dcd_s1;
    s_next.dsr_s1 = dsr;
    s_next.dsr_s2 = s_reg.dsr_s1;

    // Bus handshake: a full FIFO stalls data writes
    s_next.ack = (read | write) & !s_reg.ack & !(write & (idx == IDX_TX_DATA) & fifo_full);
    if ((read | write) & !s_reg.ack) begin
      case (idx)
        IDX_FIRST_SYNC: s_next.rdata = {24'h000000, s_reg.first_sync};
        IDX_SECOND_SYNC: s_next.rdata = {24'h000000, s_reg.second_sync};
        IDX_SPECIAL: s_next.rdata = {24'h000000, s_reg.special};
        IDX_SYNC_COUNT: s_next.rdata = {24'h000000, s_reg.sync_count};
        IDX_RECORD_LEN: s_next.rdata = {16'h0000, s_reg.record_len};
        IDX_FLAGS: s_next.rdata = {16'h0000, s_reg.flags};
        IDX_IDLE_FILL: s_next.rdata = {16'h0000, s_reg.idle_fill};
        IDX_THRESHOLD: s_next.rdata = {16'h0000, s_reg.threshold};
        IDX_PAD_CHAR: s_next.rdata = {24'h000000, s_reg.pad_char};
        IDX_PAD_COUNT: s_next.rdata = {24'h000000, s_reg.pad_count};
        IDX_OPEN_HOLD: s_next.rdata = {24'h000000, s_reg.open_hold};
        IDX_CONTROL: s_next.rdata = {31'h00000000, s_reg.cont_rts};
        IDX_TX_LENGTH: s_next.rdata = {16'h0000, s_reg.tx_len};
        IDX_STATUS: s_next.rdata = {29'h00000000, s_reg.status};
        IDX_IRQ_MASK: s_next.rdata = {29'h00000000, s_reg.mask};
        IDX_CHAN_STATE: begin
          s_next.rdata = {21'h000000, s_reg.fifo_cnt, s_reg.op_st, s_reg.tx_st, s_reg.rts};
        end
        default: s_next.rdata = 32'h00000000;
      endcase
    end

    if (wr_acc) begin
      case (idx)
        IDX_FIRST_SYNC: s_next.first_sync = merge8(s_reg.first_sync, writedata, byteenable);
        IDX_SECOND_SYNC: begin
          s_next.second_sync = merge8(s_reg.second_sync, writedata, byteenable);
        end
        IDX_SPECIAL: s_next.special = merge8(s_reg.special, writedata, byteenable);
        IDX_SYNC_COUNT: s_next.sync_count = merge8(s_reg.sync_count, writedata, byteenable);
        IDX_RECORD_LEN: begin
          s_next.record_len = merge16(s_reg.record_len, writedata, byteenable);
        end
        IDX_FLAGS: s_next.flags = merge16(s_reg.flags, writedata, byteenable);
        IDX_IDLE_FILL: s_next.idle_fill = merge16(s_reg.idle_fill, writedata, byteenable);
        IDX_THRESHOLD: s_next.threshold = merge16(s_reg.threshold, writedata, byteenable);
        IDX_PAD_CHAR: s_next.pad_char = merge8(s_reg.pad_char, writedata, byteenable);
        IDX_PAD_COUNT: s_next.pad_count = merge8(s_reg.pad_count, writedata, byteenable);
        IDX_OPEN_HOLD: s_next.open_hold = merge8(s_reg.open_hold, writedata, byteenable);
        IDX_CONTROL: begin
          if (byteenable[0]) begin
            s_next.cont_rts = writedata[CTL_CONT_RTS];
          end
        end
        IDX_TX_LENGTH: s_next.tx_len = merge16(s_reg.tx_len, writedata, byteenable);
        IDX_TX_DATA: begin
          if (byteenable[0]) begin
            s_next.mem[s_reg.wr_ptr] = writedata[7:0];
            s_next.wr_ptr = s_reg.wr_ptr + 4'h1;
          end
        end
        IDX_IRQ_MASK: begin
          if (byteenable[0]) begin
            s_next.mask = writedata[ST_WIDTH-1:0];
          end
        end
        default: s_next.ack = s_next.ack;
      endcase
    end

    // Line byte stream
    if (s_reg.tx_vld & tx_ready) begin
      s_next.tx_vld = 1'b0;
    end
    case (s_reg.tx_st)
      TX_IDLE: begin
        if (go_pulse) begin
          s_next.tx_st = TX_FILL;
          s_next.tx_left = s_reg.tx_len;
        end else if (s_reg.cont_rts & can_load) begin
          s_next.tx_byte = s_reg.idle_fill[7:0];
          s_next.tx_vld = 1'b1;
          s_next.tx_kind = K_IDLE;
        end
      end
      TX_FILL: begin
        if (fifo_cnt_w >= fill_target) begin
          s_next.tx_st = TX_SYNC;
          s_next.rep_left = s_reg.sync_count;
        end
      end
      TX_SYNC: begin
        if (can_load) begin
          if (s_reg.rep_left == 8'h00) begin
            s_next.tx_st = TX_DATA;
          end else begin
            s_next.tx_byte = s_reg.first_sync;
            s_next.tx_vld = 1'b1;
            s_next.tx_kind = K_SYNC;
            s_next.rep_left = s_reg.rep_left - 8'h01;
          end
        end
      end
      TX_DATA: begin
        if (s_reg.tx_left == 16'h0000) begin
          s_next.tx_st = TX_PAD;
          s_next.rep_left = s_reg.pad_count;
        end else if (can_load & (s_reg.fifo_cnt != 5'h00)) begin
          s_next.tx_byte = s_reg.mem[s_reg.rd_ptr];
          s_next.tx_vld = 1'b1;
          s_next.tx_kind = K_DATA;
          s_next.rd_ptr = s_reg.rd_ptr + 4'h1;
          s_next.tx_left = s_reg.tx_left - 16'h0001;
        end
      end
      TX_PAD: begin
        if (can_load) begin
          if (s_reg.rep_left == 8'h00) begin
            s_next.tx_st = TX_IDLE;
            ev[ST_TX_DONE] = 1'b1;
          end else begin
            s_next.tx_byte = s_reg.pad_char;
            s_next.tx_vld = 1'b1;
            s_next.tx_kind = K_PAD;
            s_next.rep_left = s_reg.rep_left - 8'h01;
          end
        end
      end
      default: s_next.tx_st = TX_IDLE;
    endcase
    s_next.fifo_cnt = 5'(4'(s_next.wr_ptr - s_next.rd_ptr));
    if (s_next.wr_ptr == s_next.rd_ptr) begin
      s_next.fifo_cnt = (s_reg.fifo_cnt >= 5'h08) && (s_next.wr_ptr != s_reg.rd_ptr
                         || s_next.rd_ptr == s_reg.rd_ptr) ? 5'(FIFO_DEPTH) : 5'h00;
    end

    // Open sequencer
    case (s_reg.op_st)
      O_IDLE, O_UP: begin
        if (s_reg.op_st == O_UP && !s_reg.flags[FLAG_IGNORE_DSR] && !s_reg.dsr_s2) begin
          ev[ST_DSR_LOST] = 1'b1;
        end
        if (close_pulse) begin
          s_next.op_st = O_IDLE;
          s_next.rts = 1'b0;
        end else if (open_pulse) begin
          s_next.op_st = O_WAIT;
          s_next.hold_cnt = 8'h00;
          if (s_reg.flags[FLAG_RTS_ON_OPEN]) begin
            s_next.rts = 1'b1;
          end
        end
      end
      O_WAIT: begin
        if (close_pulse) begin
          s_next.op_st = O_IDLE;
          s_next.rts = 1'b0;
        end else if (!line_ok) begin
          s_next.hold_cnt = 8'h00;
        end else if (s_reg.hold_cnt >= s_reg.open_hold) begin
          s_next.op_st = O_UP;
          ev[ST_OPEN_DONE] = 1'b1;
          if (s_reg.flags[FLAG_DROP_RTS]) begin
            s_next.rts = 1'b0;
          end
        end else if (qtr_tick) begin
          s_next.hold_cnt = s_reg.hold_cnt + 8'h01;
        end
      end
      default: s_next.op_st = O_IDLE;
    endcase

    // Sticky status, read clears only what was reported; new events win
    if (rd_acc && idx == IDX_STATUS) begin
      s_next.status = s_reg.status & ~s_reg.rdata[ST_WIDTH-1:0];
    end
    s_next.status = s_next.status | ev;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign waitrequest = (read | write) & !s_reg.ack;
  assign readdata = s_reg.rdata;
  assign irq = |(s_reg.status & s_reg.mask);
  assign first_sync_char = s_reg.first_sync;
  assign second_sync_char = s_reg.second_sync;
  assign transparent_en = s_reg.special[SPECIAL_TRANSPARENT];
  assign transmit_record_length = s_reg.record_len;
  assign split_queues = s_reg.flags[FLAG_SPLIT_QUEUES];
  assign line_mode = s_reg.flags[15:FLAG_MODE_LSB];
  assign line_mode_known = (line_mode == bit_oriented_mode) | (line_mode == char_oriented_mode) |
                           (line_mode == async_mode);
  assign timer_tick = s_reg.ticks;
  assign tx_data = s_reg.tx_byte;
  assign tx_valid = s_reg.tx_vld;
  assign rx_clear = s_reg.rx_clr;
  assign rts = s_reg.rts;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence hold_met;
    s_reg.op_st == O_WAIT && !close_pulse && line_ok && s_reg.hold_cnt >= s_reg.open_hold;
  endsequence
  sequence open_start;
    s_reg.op_st == O_IDLE && open_pulse && !close_pulse;
  endsequence

  a_sync2_load: assert property ((wr_acc && idx == IDX_SECOND_SYNC && byteenable[0])
    |=> second_sync_char == $past(writedata[7:0])) else $error("second sync not loaded");
  a_transp_sel: assert property ((wr_acc && idx == IDX_SPECIAL && byteenable[0])
    |=> transparent_en == $past(writedata[0])) else $error("transparency not set");
  a_sync_bytes: assert property ((tx_valid && s_reg.tx_kind == K_SYNC)
    |-> tx_data == first_sync_char) else $error("sync byte wrong");
  a_reclen_load: assert property ((wr_acc && idx == IDX_RECORD_LEN
    && byteenable[1:0] == 2'b11) |=> transmit_record_length == $past(writedata[15:0]))
    else $error("record length lost");
  a_tick_unit: assert property ((qtr_tick && !s_reg.flags[0] && !$changed(s_reg.flags))
    |=> timer_tick[0]) else $error("quarter tick not routed");
  a_rx_clear: assert property (rx_frame_end
    |=> rx_clear == $past(s_reg.flags[FLAG_RX_CLEAR])) else $error("receiver clear wrong");
  a_fifo_wait: assert property ((s_reg.tx_st == TX_FILL && fifo_cnt_w < fill_target)
    |=> s_reg.tx_st == TX_FILL) else $error("transmit began below threshold");
  a_rts_open: assert property ((open_start and s_reg.flags[FLAG_RTS_ON_OPEN])
    |=> rts) else $error("rts not raised on open");
  a_open_hold: assert property (hold_met |=> s_reg.op_st == O_UP ##0
    rts == ($past(s_reg.rts) && !$past(s_reg.flags[FLAG_DROP_RTS])))
    else $error("open completion wrong");
  a_open_cause: assert property ($rose(s_reg.op_st == O_UP) |-> $past(line_ok))
    else $error("open completed without modem lines");
  a_pad_bytes: assert property ((tx_valid && s_reg.tx_kind == K_PAD)
    |-> tx_data == s_reg.pad_char) else $error("pad byte wrong");
  a_idle_fill: assert property ((s_reg.tx_st == TX_IDLE && s_reg.cont_rts && !go_pulse
    && !tx_valid) |=> tx_valid && tx_data == $past(s_reg.idle_fill[7:0]))
    else $error("idle fill missing");

endmodule

// File: verif/dce_model.sv
// Purpose: Modem and line sink model for the channel far side
// Assumes: Bench commands change at rising clock edges
// Notes: Modem lines move only when commanded; slow mode holds tx_ready low every other cycle
`timescale 1ns/1ps
module dce_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bench commands
  input wire logic carrier_on,
  input wire logic dsr_on,
  input wire logic slow,
  // Line and modem
  output logic tx_ready,
  output logic dcd,
  output logic dsr
);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_ready <= 1'b0;
      dcd <= 1'b0;
      dsr <= 1'b0;
    end else begin
      tx_ready <= slow ? !tx_ready : 1'b1;
      dcd <= carrier_on;
      dsr <= dsr_on;
    end
  end
endmodule

// File: verif/test_sync_serial_channel_params.sv
// Purpose: Register, framing, timer and open sequence tests
// Assumes: Short quarter tick of 8 cycles
// Notes: Bus accesses wait for waitrequest low
`timescale 1ns/1ps
module test_sync_serial_channel_params;
  import chan_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [9:0] address = 10'h000;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'h0;
  logic rx_frame_end = 1'b0;
  logic carrier_on = 1'b0;
  logic dsr_on = 1'b0;
  logic slow = 1'b1;
  logic [31:0] readdata, rv;
  logic waitrequest, irq, transparent_en, split_queues, line_mode_known;
  logic [7:0] first_sync_char, second_sync_char, tx_data;
  logic [15:0] transmit_record_length;
  logic [2:0] line_mode;
  logic [3:0] timer_tick;
  logic tx_valid, tx_ready, rx_clear, dcd, dsr, rts;
  int num_errors = 0;
  int checked = 0;
  int cnt0 = 0;
  int cnt1 = 0;
  logic [7:0] q[$];
  logic [7:0] idx_t [11] = '{8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0e, 8'h10, 8'h12, 8'h14,
    8'h15, 8'h16};
  logic [2:0] md [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
  logic [7:0] ef [8] = '{8'h16, 8'h16, 8'h31, 8'h32, 8'h33, 8'h55, 8'h55, 8'h55};

  always #2 clk = ~clk;

  sync_serial_channel_params #(.QTR_CYCLES(8)) uut (.clk(clk), .rst(rst), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
    .first_sync_char(first_sync_char), .second_sync_char(second_sync_char),
    .transparent_en(transparent_en), .transmit_record_length(transmit_record_length),
    .split_queues(split_queues), .line_mode(line_mode), .line_mode_known(line_mode_known),
    .timer_tick(timer_tick), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_frame_end(rx_frame_end), .rx_clear(rx_clear), .dcd(dcd), .dsr(dsr), .rts(rts));

  dce_model far (.clk(clk), .rst(rst), .carrier_on(carrier_on), .dsr_on(dsr_on),
    .slow(slow), .tx_ready(tx_ready), .dcd(dcd), .dsr(dsr));

  // Line byte capture and tick counting
  always @(posedge clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) q.push_back(tx_data);
    if (timer_tick[0] === 1'b1) cnt0 <= cnt0 + 1;
    if (timer_tick[1] === 1'b1) cnt1 <= cnt1 + 1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  task automatic bus(input logic we, input logic [7:0] idx, input logic [31:0] d,
      input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    address <= {idx, 2'b00};
    write <= we;
    read <= !we;
    writedata <= d;
    byteenable <= be;
    @(posedge clk);
    while (waitrequest !== 1'b0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (n == 100) num_errors++;
    rv = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [3:0] be);
    bus(1'b1, idx, d, be);
  endtask

  task automatic rd(input logic [7:0] idx);
    bus(1'b0, idx, 32'h0, 4'hf);
  endtask

  task automatic rx_pulse(input logic exp);
    @(posedge clk);
    rx_frame_end <= 1'b1;
    @(posedge clk);
    rx_frame_end <= 1'b0;
    @(negedge clk);
    chk(rx_clear, exp, "rx clear");
  endtask

  task end_sim;
    $display("errors %0d, checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    num_errors++;
    end_sim;
  end

  initial begin
    logic w;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    foreach (idx_t[i]) begin
      w = idx_t[i] inside {8'h0c, 8'h0e, 8'h10, 8'h12};
      rd(idx_t[i]);
      chk(rv, 32'h0, "reset value");
      wr(idx_t[i], 32'h5aa5, w ? 4'h3 : 4'h1);
      rd(idx_t[i]);
      chk(rv, w ? 32'h5aa5 : 32'ha5, "readback");
    end
    chk(second_sync_char, 8'ha5, "second sync");
    chk(first_sync_char, 8'ha5, "first sync");
    chk(transmit_record_length, 16'h5aa5, "record length");
    chk(transparent_en, 1'b1, "transparency on");
    wr(IDX_SPECIAL, 32'hfe, 4'h1);
    chk(transparent_en, 1'b0, "transparency off");
    rd(8'h30);
    chk(rv, 32'h0, "unmapped");
    foreach (md[i]) begin
      wr(IDX_FLAGS, {16'h0, md[i], 13'h0020}, 4'h3);
      chk(line_mode, md[i], "mode");
      chk(line_mode_known, md[i] != 3'h1, "mode known");
      chk(split_queues, 1'b1, "split queues");
    end
    wr(IDX_FLAGS, 32'h0012, 4'h3);
    chk(split_queues, 1'b0, "single queue");
    cnt0 = 0;
    cnt1 = 0;
    repeat (1930) @(posedge clk);
    @(negedge clk);
    chk(cnt0 inside {[241:242]}, 1'b1, "quarter ticks");
    chk(cnt1 inside {[1:2]}, 1'b1, "minute ticks");
    rx_pulse(1'b1);
    wr(IDX_FLAGS, 32'h0, 4'h3);
    rx_pulse(1'b0);
    wr(IDX_FIRST_SYNC, 32'h16, 4'h1);
    wr(IDX_SYNC_COUNT, 32'h2, 4'h1);
    wr(IDX_PAD_CHAR, 32'h55, 4'h1);
    wr(IDX_PAD_COUNT, 32'h3, 4'h1);
    wr(IDX_THRESHOLD, 32'h5, 4'h3);
    wr(IDX_TX_LENGTH, 32'h3, 4'h3);
    wr(IDX_IRQ_MASK, 32'h1, 4'h1);
    q.delete();
    wr(IDX_TX_DATA, 32'h31, 4'h1);
    wr(IDX_TX_DATA, 32'h32, 4'h1);
    wr(IDX_CONTROL, 32'h4, 4'h1);
    repeat (30) @(posedge clk);
    chk(q.size(), 0, "early line data");
    wr(IDX_TX_DATA, 32'h33, 4'h1);
    repeat (80) @(posedge clk);
    @(negedge clk);
    chk(q.size(), 8, "frame size");
    foreach (ef[i]) chk(q[i], ef[i], "frame byte");
    chk(irq, 1'b1, "irq raised");
    rd(IDX_STATUS);
    chk(rv[0], 1'b1, "tx done");
    chk(irq, 1'b0, "irq cleared");
    wr(IDX_IDLE_FILL, 32'hab7e, 4'h3);
    wr(IDX_CONTROL, 32'h1, 4'h1);
    repeat (4) @(negedge clk);
    chk(tx_valid, 1'b1, "idle valid");
    chk(tx_data, 8'h7e, "idle byte");
    wr(IDX_CONTROL, 32'h0, 4'h1);
    @(posedge clk);
    dsr_on <= 1'b1;
    wr(IDX_OPEN_HOLD, 32'h2, 4'h1);
    wr(IDX_FLAGS, 32'h01c0, 4'h3);
    wr(IDX_CONTROL, 32'h2, 4'h1);
    repeat (3) @(negedge clk);
    chk(rts, 1'b1, "rts on open");
    repeat (60) @(posedge clk);
    rd(IDX_STATUS);
    chk(rv[1], 1'b0, "open without carrier");
    @(posedge clk);
    carrier_on <= 1'b1;
    rd(IDX_STATUS);
    chk(rv[1], 1'b0, "open before hold");
    repeat (40) @(negedge clk);
    chk(rts, 1'b0, "rts dropped");
    chk(irq, 1'b0, "irq masked");
    rd(IDX_STATUS);
    chk(rv[1], 1'b1, "open done");
    @(posedge clk);
    dsr_on <= 1'b0;
    repeat (10) @(posedge clk);
    rd(IDX_STATUS);
    chk(rv[2], 1'b1, "dsr lost");
    rd(IDX_CHAN_STATE);
    chk(rv[5:4], 2'h3, "open state");
    wr(IDX_CONTROL, 32'h8, 4'h1);
    rd(IDX_CHAN_STATE);
    chk(rv[10:0], 11'h000, "closed");
    end_sim;
  end
endmodule
